// [dmp_cfg.svh]
/*
 * Constants of the data memory and register page block: sizes, register
 * addresses, pages, field positions and reset values.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef DMP_CFG_SVH
`define DMP_CFG_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define DMP_RAM_BYTES    256
`define DMP_XRAM_BYTES   4096
`define DMP_LOW_TOP      8'h7F

// ****************************************************************
// Register addresses
// ****************************************************************
`define DMP_ADDR_PORT0   8'h80
`define DMP_ADDR_SP      8'h81
`define DMP_ADDR_CTRL    8'h84
`define DMP_ADDR_MIDDLE  8'h85
`define DMP_ADDR_BOTTOM  8'h86
`define DMP_ADDR_PAGE    8'hA7
`define DMP_ADDR_PSW     8'hD0

// ****************************************************************
// Pages
// ****************************************************************
`define DMP_PAGE_MAIN    8'h00
`define DMP_PAGE_CAN     8'h0C
`define DMP_PAGE_CONFIG  8'h0F

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define DMP_PSW_BANK_LO  3
`define DMP_PSW_BANK_HI  4
`define DMP_CTRL_EN_BIT  0
`define DMP_BIT_BASE_HI  4'h2
`define DMP_SP_RESET     8'h07
`define DMP_PSW_RESET    8'h00
`define DMP_PORT0_RESET  8'hFF
`define DMP_PAGE_RESET   8'h00
`define DMP_EN_RESET     1'b1

`endif

// [dmp_pkg.sv]
/*
 * Types shared by the data memory and register page block.
 * Assumes the constants header is on the include path.
 */
`include "dmp_cfg.svh"

package dmp_pkg;

    // Where the current access lands
    typedef enum logic [1:0] {
        DMP_TGT_RAM,
        DMP_TGT_SFR_LOCAL,
        DMP_TGT_SFR_EXT
    } dmp_target_t;

    typedef logic [7:0] dmp_byte_t;

endpackage

// [dmp_page_if.sv]
/*
 * Carrier between the memory decoder and the page stack: software
 * writes into the stack, interrupt events and the stack contents.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps

interface dmp_page_if;
    dmp_pkg::dmp_byte_t wdata;
    logic               wr_page;
    logic               wr_middle;
    logic               wr_bottom;
    logic               wr_ctrl;
    logic               int_enter;
    logic               int_can;
    logic               int_return;
    dmp_pkg::dmp_byte_t page;
    dmp_pkg::dmp_byte_t middle;
    dmp_pkg::dmp_byte_t bottom;
    logic               auto_en;

    modport decoder (
        output wdata, wr_page, wr_middle, wr_bottom, wr_ctrl,
        output int_enter, int_can, int_return,
        input  page, middle, bottom, auto_en
    );
    modport stack (
        input  wdata, wr_page, wr_middle, wr_bottom, wr_ctrl,
        input  int_enter, int_can, int_return,
        output page, middle, bottom, auto_en
    );
endinterface

// [dmp_page_stack.sv]
/*
 * Three-byte register page stack with automatic paging control.
 * Assumes interrupt entry and return arrive as one-cycle pulses.
 */
`timescale 1ns/10ps
`include "dmp_cfg.svh"

module dmp_page_stack (
    input  wire logic   sys_clk, // System clock
    input  wire logic   reset,   // Async reset, active high
    dmp_page_if.stack   pg       // Decoder side
);

    dmp_pkg::dmp_byte_t next_page;
    dmp_pkg::dmp_byte_t next_middle;
    dmp_pkg::dmp_byte_t next_bottom;
    logic               next_auto_en;
    logic               do_push;
    logic               do_pop;
    dmp_pkg::dmp_byte_t entry_page;

    assign do_push = pg.int_enter & pg.auto_en;
    assign do_pop  = pg.int_return & pg.auto_en & ~pg.int_enter;

    assign entry_page = pg.int_can ? `DMP_PAGE_CAN : `DMP_PAGE_MAIN;

    // ****************************************************************
    // Next state, interrupt events beat software writes
    // ****************************************************************
    always_comb begin
        next_page    = pg.page;
        next_middle  = pg.middle;
        next_bottom  = pg.bottom;
        next_auto_en = pg.auto_en;
        if (pg.wr_page)
            next_page = pg.wdata;
        if (pg.wr_middle)
            next_middle = pg.wdata;
        if (pg.wr_bottom)
            next_bottom = pg.wdata;
        if (pg.wr_ctrl)
            next_auto_en = pg.wdata[`DMP_CTRL_EN_BIT];
        if (do_push) begin
            next_bottom = pg.middle;
            next_middle = pg.page;
            next_page   = entry_page;
        end
        if (do_pop) begin
            next_page   = pg.middle;
            next_middle = pg.bottom;
            next_bottom = `DMP_PAGE_RESET;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pg.page    <= `DMP_PAGE_RESET;
            pg.middle  <= `DMP_PAGE_RESET;
            pg.bottom  <= `DMP_PAGE_RESET;
            pg.auto_en <= `DMP_EN_RESET;
        end else begin
            pg.page    <= next_page;
            pg.middle  <= next_middle;
            pg.bottom  <= next_bottom;
            pg.auto_en <= next_auto_en;
        end
    end

endmodule

// [dmp_data_mem.sv]
/*
 * Data memory decoder: internal RAM with register banks, bit area and
 * stack, register space with paging, and the on-chip external RAM.
 * Assumes one core strobe per cycle and
 * same-cycle peripheral register reads.
 */
`timescale 1ns/10ps
`include "dmp_cfg.svh"

// Behaviour
// - 256 internal bytes plus 4096 external
// - Lower half direct and indirect
// - Upper half RAM by indirect only
// - Direct upper addresses reach registers
// - Four banks chosen by status bits
// - Pointer from bank register zero/one
// - Bit area maps 0x20 to 0x2F
// - Bit or byte from operand type
// - Pointer holds last used slot
// - Pointer resets to 0x07
// - Registers ending 0/8 bit addressable
// - Eight-bit page, pages 0,C,F populated
// - Interrupt entry shifts stack down
// - Entry loads page 0, CAN 0x0C
// - Return pops, bottom refills zero
// - Stack writes never push or pop
// - Auto paging enable, reset on
// - All-page registers ignore page select
// - Disabled paging freezes stack
// - Control at 0x84 page 0x0F
// - Page select at 0xA7, all pages
module dmp_data_mem (
    input  wire logic        sys_clk,       // System clock, 100 MHz
    input  wire logic        reset,         // Async reset, active high
    input  wire logic [7:0]  mem_addr,      // Byte or bit address
    input  wire logic [7:0]  mem_wdata,     // Write data, bit in [0]
    input  wire logic        mem_wr,        // Write strobe
    input  wire logic        mem_rd,        // Read strobe
    input  wire logic        mem_indirect,  // Indirect through pointer
    input  wire logic        mem_ptr_sel,   // Pointer reg one if high
    input  wire logic        mem_bit,       // Single bit operand
    output logic      [7:0]  mem_rdata,     // Read data, next cycle
    input  wire logic        stk_push,      // Stack push strobe
    input  wire logic        stk_pop,       // Stack pop strobe
    input  wire logic [7:0]  stk_wdata,     // Push data
    output logic      [7:0]  stk_rdata,     // Pop data, next cycle
    input  wire logic        int_vector,    // Interrupt entry pulse
    input  wire logic        int_from_can,  // Entry is CAN source
    input  wire logic        int_return,    // Interrupt return pulse
    input  wire logic [11:0] xram_addr,     // External RAM address
    input  wire logic [7:0]  xram_wdata,    // External RAM write data
    input  wire logic        xram_wr,       // External RAM write
    input  wire logic        xram_rd,       // External RAM read
    output logic      [7:0]  xram_rdata,    // External RAM data, next
    output logic      [7:0]  sfr_ext_addr,  // Peripheral reg address
    output logic      [7:0]  sfr_ext_page,  // Peripheral reg page
    output logic      [7:0]  sfr_ext_wdata, // Peripheral write data
    output logic             sfr_ext_wr,    // Peripheral write strobe
    output logic             sfr_ext_rd,    // Peripheral read strobe
    input  wire logic [7:0]  sfr_ext_rdata, // Peripheral read data
    output logic      [7:0]  page_select,   // Current page
    output logic      [7:0]  program_status_word, // Status word
    output logic      [7:0]  port_zero_reg, // Port zero latch
    output logic      [7:0]  stack_pointer  // Stack pointer
);

    // ****************************************************************
    // Storage
    // ****************************************************************
    dmp_pkg::dmp_byte_t ram  [`DMP_RAM_BYTES];
    dmp_pkg::dmp_byte_t xram [`DMP_XRAM_BYTES];

    dmp_page_if pg ();

    dmp_page_stack u_stack (
        .sys_clk (sys_clk),
        .reset   (reset),
        .pg      (pg.stack)
    );

    // ****************************************************************
    // Address formation
    // ****************************************************************
    wire logic [1:0]  bank;
    wire logic [7:0]  ptr_index;
    wire logic [7:0]  ptr_value;
    wire logic [7:0]  bit_byte;
    wire logic [2:0]  bit_pos;
    wire logic [7:0]  bit_mask;
    wire logic [7:0]  tgt_addr;
    wire logic        is_sfr;
    wire logic        access;

    assign bank = {program_status_word[`DMP_PSW_BANK_HI],
                   program_status_word[`DMP_PSW_BANK_LO]};
    assign ptr_index = {3'h0, bank, 2'h0, mem_ptr_sel};
    assign ptr_value = ram[ptr_index];

    assign bit_byte = mem_addr[7] ? {mem_addr[7:3], 3'h0}
                                  : {`DMP_BIT_BASE_HI, mem_addr[6:3]};
    assign bit_pos  = mem_addr[2:0];
    assign bit_mask = 8'h01 << bit_pos;

    assign tgt_addr = mem_bit      ? bit_byte
                    : mem_indirect ? ptr_value
                    : mem_addr;
    assign is_sfr = tgt_addr[7] & (mem_bit | ~mem_indirect);
    assign access = mem_wr | mem_rd;

    // ****************************************************************
    // Register decode
    // ****************************************************************
    wire logic hit_port0;
    wire logic hit_sp;
    wire logic hit_psw;
    wire logic hit_page;
    wire logic hit_ctrl;
    wire logic hit_middle;
    wire logic hit_bottom;
    wire logic on_config;
    wire logic hit_local;
    dmp_pkg::dmp_target_t target;

    assign hit_port0 = tgt_addr == `DMP_ADDR_PORT0;
    assign hit_sp    = tgt_addr == `DMP_ADDR_SP;
    assign hit_psw   = tgt_addr == `DMP_ADDR_PSW;
    assign hit_page  = tgt_addr == `DMP_ADDR_PAGE;
    assign on_config  = pg.page == `DMP_PAGE_CONFIG;
    assign hit_ctrl   = on_config & (tgt_addr == `DMP_ADDR_CTRL);
    assign hit_middle = on_config & (tgt_addr == `DMP_ADDR_MIDDLE);
    assign hit_bottom = on_config & (tgt_addr == `DMP_ADDR_BOTTOM);
    assign hit_local  = hit_port0 | hit_sp | hit_psw | hit_page
                      | hit_ctrl | hit_middle | hit_bottom;

    assign target = !is_sfr   ? dmp_pkg::DMP_TGT_RAM
                  : hit_local ? dmp_pkg::DMP_TGT_SFR_LOCAL
                  : dmp_pkg::DMP_TGT_SFR_EXT;

    // ****************************************************************
    // Read path
    // ****************************************************************
    dmp_pkg::dmp_byte_t local_rd;
    wire logic [7:0]    byte_rd;
    wire logic [7:0]    next_rdata;
    wire logic [7:0]    merged;
    wire logic [7:0]    store_data;

    always_comb begin
        local_rd = 8'h00;
        if (hit_port0)
            local_rd = port_zero_reg;
        if (hit_sp)
            local_rd = stack_pointer;
        if (hit_psw)
            local_rd = program_status_word;
        if (hit_page)
            local_rd = pg.page;
        if (hit_ctrl)
            local_rd = {7'h00, pg.auto_en};
        if (hit_middle)
            local_rd = pg.middle;
        if (hit_bottom)
            local_rd = pg.bottom;
    end

    assign byte_rd = (target == dmp_pkg::DMP_TGT_RAM) ? ram[tgt_addr]
                   : (target == dmp_pkg::DMP_TGT_SFR_LOCAL) ? local_rd
                   : sfr_ext_rdata;
    assign next_rdata = mem_bit ? {7'h00, |(byte_rd & bit_mask)}
                                : byte_rd;

    // Bit writes merge into the old byte
    assign merged = mem_wdata[0] ? (byte_rd | bit_mask)
                                 : (byte_rd & ~bit_mask);
    assign store_data = mem_bit ? merged : mem_wdata;

    // ****************************************************************
    // Peripheral register port
    // ****************************************************************
    wire logic ext_hit;

    assign ext_hit       = access & (target == dmp_pkg::DMP_TGT_SFR_EXT);
    assign sfr_ext_addr  = tgt_addr;
    assign sfr_ext_page  = pg.page;
    assign sfr_ext_wdata = store_data;
    assign sfr_ext_wr    = ext_hit & mem_wr;
    // Bit writes also read for the merge
    assign sfr_ext_rd    = ext_hit & (mem_rd | mem_bit);

    // ****************************************************************
    // Local register writes
    // ****************************************************************
    wire logic lw;

    assign lw = mem_wr & (target == dmp_pkg::DMP_TGT_SFR_LOCAL);

    assign pg.wdata      = store_data;
    assign pg.wr_page    = lw & hit_page;
    assign pg.wr_middle  = lw & hit_middle;
    assign pg.wr_bottom  = lw & hit_bottom;
    assign pg.wr_ctrl    = lw & hit_ctrl;
    assign pg.int_enter  = int_vector;
    assign pg.int_can    = int_from_can;
    assign pg.int_return = int_return;
    assign page_select   = pg.page;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            program_status_word <= `DMP_PSW_RESET;
            port_zero_reg       <= `DMP_PORT0_RESET;
        end else begin
            if (lw & hit_psw)
                program_status_word <= store_data;
            if (lw & hit_port0)
                port_zero_reg <= store_data;
        end
    end

    // ****************************************************************
    // Stack pointer
    // ****************************************************************
    wire logic [7:0] sp_inc;
    wire logic [7:0] sp_dec;
    logic      [7:0] next_sp;

    assign sp_inc = stack_pointer + 8'h01;
    assign sp_dec = stack_pointer - 8'h01;

    always_comb begin
        next_sp = stack_pointer;
        if (lw & hit_sp)
            next_sp = store_data;
        if (stk_push)
            next_sp = sp_inc;
        else if (stk_pop)
            next_sp = sp_dec;
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset)
            stack_pointer <= `DMP_SP_RESET;
        else
            stack_pointer <= next_sp;
    end

    // ****************************************************************
    // Internal RAM write port
    // ****************************************************************
    wire logic       ram_we;
    wire logic [7:0] ram_waddr;
    wire logic [7:0] ram_wdata;

    // push lands at pointer plus one
    assign ram_we    = stk_push
                     | (mem_wr & (target == dmp_pkg::DMP_TGT_RAM));
    assign ram_waddr = stk_push ? sp_inc : tgt_addr;
    assign ram_wdata = stk_push ? stk_wdata : store_data;

    genvar gi;
    generate
        for (gi = 0; gi < `DMP_RAM_BYTES; gi++) begin : g_ram
            always_ff @(posedge sys_clk or posedge reset) begin
                if (reset)
                    ram[gi] <= 8'h00;
                else if (ram_we && ram_waddr == 8'(gi))
                    ram[gi] <= ram_wdata;
            end
        end
    endgenerate

    generate
        for (gi = 0; gi < `DMP_XRAM_BYTES; gi++) begin : g_xram
            always_ff @(posedge sys_clk) begin
                if (xram_wr && xram_addr == 12'(gi))
                    xram[gi] <= xram_wdata;
            end
        end
    endgenerate

    // ****************************************************************
    // Registered read data
    // ****************************************************************
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            mem_rdata  <= 8'h00;
            stk_rdata  <= 8'h00;
            xram_rdata <= 8'h00;
        end else begin
            if (mem_rd)
                mem_rdata <= next_rdata;
            if (stk_pop)
                stk_rdata <= ram[stack_pointer];
            if (xram_rd)
                xram_rdata <= xram[xram_addr];
        end
    end

endmodule

// [dmp_data_mem_properties.sv]
/*
 * Port-level checks of the data memory decoder.
 * Assumes one core strobe per cycle and an async active-high reset.
 */
`timescale 1ns/10ps

module dmp_data_mem_properties (
    input wire logic       sys_clk,      // Clock
    input wire logic       reset,        // Async reset
    input wire logic [7:0] mem_addr,     // Core address
    input wire logic [7:0] mem_wdata,    // Core write data
    input wire logic       mem_wr,       // Core write
    input wire logic       mem_rd,       // Core read
    input wire logic       mem_indirect, // Indirect access
    input wire logic       mem_bit,      // Bit operand
    input wire logic       stk_push,     // Push strobe
    input wire logic       stk_pop,      // Pop strobe
    input wire logic       int_vector,   // Interrupt entry
    input wire logic       int_from_can, // CAN source
    input wire logic       int_return,   // Interrupt return
    input wire logic       sfr_ext_rd,   // External read
    input wire logic       sfr_ext_wr,   // External write
    input wire logic [7:0] sfr_ext_addr, // External address
    input wire logic [7:0] sfr_ext_page, // External page
    input wire logic [7:0] page_select,  // Current page
    input wire logic [7:0] stack_pointer // Stack pointer
);
    // ************************************************************
    // Decode and shadow of the paging enable
    // ************************************************************
    logic en_q;
    wire  dir_byte  = !mem_indirect && !mem_bit;
    wire  cfg_pg    = page_select == 8'h0F;
    wire  cfg_hit   = cfg_pg && mem_addr >= 8'h84 && mem_addr <= 8'h86;
    wire  local_hit = mem_addr == 8'h80 || mem_addr == 8'h81 ||
                      mem_addr == 8'hA7 || mem_addr == 8'hD0 || cfg_hit;
    wire  ctrl_wr   = mem_wr && dir_byte && cfg_pg && mem_addr == 8'h84;

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset)
            en_q <= 1'b1;
        else if (ctrl_wr)
            en_q <= mem_wdata[0];
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    property p_sp_push;
        stk_push |=> stack_pointer == $past(stack_pointer) + 8'h01;
    endproperty
    a_sp_push: assert property (p_sp_push)
        else $error("push missed");

    property p_sp_pop;
        stk_pop && !stk_push |=>
            stack_pointer == $past(stack_pointer) - 8'h01;
    endproperty
    a_sp_pop: assert property (p_sp_pop)
        else $error("pop missed");

    property p_ent_page;
        int_vector && en_q |=>
            page_select == ($past(int_from_can) ? 8'h0C : 8'h00);
    endproperty
    a_ent_page: assert property (p_ent_page)
        else $error("bad entry page");

    property p_auto_off;
        (int_vector || int_return) && !en_q && !mem_wr |=>
            $stable(page_select);
    endproperty
    a_auto_off: assert property (p_auto_off)
        else $error("page moved");

    property p_ret_page;
        int_vector && en_q && !int_return && !mem_wr ##1
        int_return && !int_vector && !mem_wr |=>
            page_select == $past(page_select, 2);
    endproperty
    a_ret_page: assert property (p_ret_page)
        else $error("page not restored");

    property p_ext_rd;
        mem_rd && dir_byte && mem_addr[7] && !local_hit |->
            sfr_ext_rd && sfr_ext_addr == mem_addr &&
            sfr_ext_page == page_select;
    endproperty
    a_ext_rd: assert property (p_ext_rd)
        else $error("read not external");

    property p_no_ext;
        (mem_rd || mem_wr) && !mem_bit && (mem_indirect || !mem_addr[7])
            |-> !sfr_ext_rd && !sfr_ext_wr;
    endproperty
    a_no_ext: assert property (p_no_ext)
        else $error("RAM went external");

    property p_local_rd;
        mem_rd && dir_byte && local_hit |-> !sfr_ext_rd;
    endproperty
    a_local_rd: assert property (p_local_rd)
        else $error("local went external");

    property p_page_wr;
        mem_wr && dir_byte && mem_addr == 8'hA7 && !int_vector &&
        !int_return |=> page_select == $past(mem_wdata);
    endproperty
    a_page_wr: assert property (p_page_wr)
        else $error("page write lost");
endmodule

bind dmp_data_mem dmp_data_mem_properties u_props (
    .sys_clk, .reset, .mem_addr, .mem_wdata, .mem_wr, .mem_rd,
    .mem_indirect, .mem_bit, .stk_push, .stk_pop, .int_vector,
    .int_from_can, .int_return, .sfr_ext_rd, .sfr_ext_wr,
    .sfr_ext_addr, .sfr_ext_page, .page_select, .stack_pointer
);

// [dmp_periph_model.sv]
/*
 * Peripheral register model behind the external register port.
 * Assumes reads are answered in the cycle of the read strobe.
 */
`timescale 1ns/10ps

module dmp_periph_model (
    input  wire logic       sys_clk, // Clock
    input  wire logic [7:0] addr,    // Register address
    input  wire logic [7:0] page,    // Register page
    input  wire logic [7:0] wdata,   // Write data
    input  wire logic       wr,      // Write strobe
    input  wire logic       rd,      // Read strobe
    output logic      [7:0] rdata    // Read data, same cycle
);
    logic [7:0] regs [0:15][0:127];
    logic [7:0] junk = 8'hA5;

    initial regs = '{default: 8'h00};

    always @(posedge sys_clk) begin
        junk <= ~junk;
        if (wr)
            regs[page[3:0]][addr[6:0]] <= wdata;
    end

    // Unselected bus shows a toggling pattern
    assign rdata = rd ? regs[page[3:0]][addr[6:0]] : junk;
endmodule

// [data_memory_and_sfr_paging_test.sv]
/*
 * Self-checking bench of the data memory decoder.
 * Assumes the peripheral model answers register reads in the same cycle.
 */
`timescale 1ns/10ps

`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
    num_errors++; $display("BAD %s exp %h got %h", n, e, s); end end

module data_memory_and_sfr_paging_test;
    logic        sys_clk, reset, mem_wr, mem_rd, mem_indirect, mem_ptr_sel;
    logic        mem_bit, stk_push, stk_pop, int_vector, int_from_can;
    logic        int_return, xram_wr, xram_rd, sfr_ext_wr, sfr_ext_rd;
    logic [7:0]  mem_addr, mem_wdata, mem_rdata, stk_wdata, stk_rdata;
    logic [7:0]  xram_wdata, xram_rdata, sfr_ext_addr, sfr_ext_page;
    logic [7:0]  sfr_ext_wdata, sfr_ext_rdata, page_select;
    logic [7:0]  program_status_word, port_zero_reg, stack_pointer;
    logic [11:0] xram_addr;
    int          num_errors = 0, cmp_count = 0, cyc = 0;

    // Flags wr,ind,ptr,bit; address; write data; expected read
    // page set first, mapped addresses only
    logic [27:0] rows [31] = '{
        28'h0_81_00_07, 28'h0_80_00_FF, 28'h8_A7_0C_00, 28'h0_80_00_FF,
        28'h9_81_00_00, 28'h0_80_00_FD, 28'h8_90_77_00, 28'h8_A7_0F_00,
        28'h0_84_00_01, 28'h0_90_00_00, 28'h8_A7_0C_00, 28'h0_90_00_77,
        28'h0_A7_00_0C, 28'h8_A7_00_00, 28'h8_30_A5_00, 28'h0_30_00_A5,
        28'h8_00_30_00, 28'h4_00_00_A5, 28'h8_01_90_00, 28'hE_00_3C_00,
        28'h6_00_00_3C, 28'h0_90_00_00, 28'h8_D0_08_00, 28'h8_08_90_00,
        28'h4_00_00_3C, 28'h8_D0_00_00, 28'h8_22_00_00, 28'h9_13_01_00,
        28'h0_22_00_08, 28'h1_13_00_01, 28'h1_12_00_00};

    dmp_data_mem DUT (
        .sys_clk, .reset, .mem_addr, .mem_wdata, .mem_wr, .mem_rd,
        .mem_indirect, .mem_ptr_sel, .mem_bit, .mem_rdata, .stk_push,
        .stk_pop, .stk_wdata, .stk_rdata, .int_vector, .int_from_can,
        .int_return, .xram_addr, .xram_wdata, .xram_wr, .xram_rd,
        .xram_rdata, .sfr_ext_addr, .sfr_ext_page, .sfr_ext_wdata,
        .sfr_ext_wr, .sfr_ext_rd, .sfr_ext_rdata, .page_select,
        .program_status_word, .port_zero_reg, .stack_pointer);

    dmp_periph_model periph (
        .sys_clk, .addr(sfr_ext_addr), .page(sfr_ext_page),
        .wdata(sfr_ext_wdata), .wr(sfr_ext_wr), .rd(sfr_ext_rd),
        .rdata(sfr_ext_rdata));

    // ************************************************************
    // Clock, timeout, tasks
    // ************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic acc(input logic [3:0] f, input logic [7:0] a, d);
        @(posedge sys_clk);
        {mem_wr, mem_indirect, mem_ptr_sel, mem_bit} <= f;
        mem_rd    <= !f[3];
        mem_addr  <= a;
        mem_wdata <= d;
        @(posedge sys_clk);
        mem_wr <= 1'b0;
        mem_rd <= 1'b0;
        #1;
    endtask

    task automatic ev(input logic [2:0] e, input logic [7:0] x);
        @(posedge sys_clk);
        {int_vector, int_from_can, int_return} <= e;
        @(posedge sys_clk);
        {int_vector, int_from_can, int_return} <= 3'b000;
        #1;
        `CHK("page", x, page_select)
    endtask

    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        {mem_wr, mem_rd, mem_indirect, mem_ptr_sel, mem_bit} = 5'b00000;
        {stk_push, stk_pop, int_vector, int_from_can} = 4'b0000;
        {int_return, xram_wr, xram_rd} = 3'b000;
        {mem_addr, mem_wdata, stk_wdata, xram_wdata, xram_addr} = 44'h0;
        reset = 1'b1;
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        for (int i = 0; i < 31; i++) begin
            acc(rows[i][27:24], rows[i][23:16], rows[i][15:8]);
            if (!rows[i][27])
                `CHK("row read", rows[i][7:0], mem_rdata)
        end
        $display("test rows done");

        acc(4'h8, 8'hA7, 8'h05);
        ev(3'b100, 8'h00);
        ev(3'b110, 8'h0C);
        ev(3'b001, 8'h00);
        ev(3'b001, 8'h05);
        ev(3'b001, 8'h00);
        acc(4'h8, 8'hA7, 8'h0F);
        acc(4'h8, 8'h86, 8'h33);
        acc(4'h8, 8'h85, 8'h22);
        `CHK("page", 8'h0F, page_select)
        ev(3'b001, 8'h22);
        ev(3'b001, 8'h33);
        acc(4'h8, 8'hA7, 8'h0F);
        acc(4'h8, 8'h84, 8'h00);
        ev(3'b110, 8'h0F);
        ev(3'b001, 8'h0F);
        acc(4'h0, 8'h84, 8'h00);
        `CHK("control", 8'h00, mem_rdata)
        $display("test paging done");

        @(posedge sys_clk);
        stk_push  <= 1'b1;
        stk_wdata <= 8'h11;
        @(posedge sys_clk);
        stk_wdata <= 8'h22;
        @(posedge sys_clk);
        stk_wdata <= 8'h33;
        @(posedge sys_clk);
        stk_push <= 1'b0;
        stk_pop  <= 1'b1;
        #1;
        `CHK("sp", 8'h0A, stack_pointer)
        @(posedge sys_clk);
        #1;
        `CHK("pop", 8'h33, stk_rdata)
        @(posedge sys_clk);
        stk_pop <= 1'b0;
        #1;
        `CHK("pop", 8'h22, stk_rdata)
        `CHK("sp", 8'h08, stack_pointer)
        acc(4'h0, 8'h08, 8'h00);
        `CHK("first push", 8'h11, mem_rdata)
        $display("test stack done");

        @(posedge sys_clk);
        {xram_wr, xram_addr, xram_wdata} <= {1'b1, 12'hFFF, 8'h5A};
        @(posedge sys_clk);
        {xram_addr, xram_wdata} <= {12'h000, 8'hA5};
        @(posedge sys_clk);
        {xram_wr, xram_rd, xram_addr} <= {1'b0, 1'b1, 12'hFFF};
        @(posedge sys_clk);
        xram_addr <= 12'h000;
        #1;
        `CHK("xram", 8'h5A, xram_rdata)
        @(posedge sys_clk);
        xram_rd <= 1'b0;
        #1;
        `CHK("xram", 8'hA5, xram_rdata)
        $display("test xram done");

        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        `CHK("sp", 8'h07, stack_pointer)
        `CHK("page", 8'h00, page_select)
        `CHK("port", 8'hFF, port_zero_reg)
        acc(4'h8, 8'hA7, 8'h05);
        @(posedge sys_clk);
        int_vector <= 1'b1;
        @(posedge sys_clk);
        {int_vector, int_return} <= 2'b01;
        @(posedge sys_clk);
        int_return <= 1'b0;
        #1;
        `CHK("page", 8'h05, page_select)
        ev(3'b100, 8'h00);
        $display("test reset done");
        final_report();
    end
endmodule
